// *** gpio_pkg.sv ***
// package: register map, field layouts and carriers for the gpio ports
package gpio_pkg;
   localparam int NUM_PORTS = 5;
   localparam int PORT_W = 8;
   localparam int NUM_KINDS = 6;
   localparam int IDX_W = 8;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PORT_ZERO_DATA = 8'h00;
   localparam logic [7:0] IDX_PORT_ONE_DATA = 8'h01;
   localparam logic [7:0] IDX_PORT_TWO_DATA = 8'h02;
   localparam logic [7:0] IDX_PORT_THREE_DATA = 8'h03;
   localparam logic [7:0] IDX_PORT_FOUR_DATA = 8'h04;
   // config index = IDX_CFG_BASE + kind * 8 + port
   localparam logic [7:0] IDX_CFG_BASE = 8'h10;
   localparam logic [7:0] IDX_ALT_SEL_ZERO = 8'h40;
   localparam logic [7:0] IDX_ALT_SEL_ONE = 8'h41;
   // config kinds, also the byte position inside port_cfg_t
   localparam logic [2:0] KIND_DRV_EN = 3'h0;
   localparam logic [2:0] KIND_PULL_UP = 3'h1;
   localparam logic [2:0] KIND_OPEN_DRAIN = 3'h2;
   localparam logic [2:0] KIND_TTL = 3'h3;
   localparam logic [2:0] KIND_ACT_LOW = 3'h4;
   localparam logic [2:0] KIND_INT_EN = 3'h5;
   localparam logic [2:0] KIND_LIMIT = 3'h6;
   localparam logic [2:0] PORT_LIMIT = 3'h5;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] PULL_UP_RESET = 8'hFF;
   localparam logic [7:0] PORT_FOUR_MASK = 8'h0F;
   localparam logic [7:0] FULL_MASK = 8'hFF;
   // alternate outputs: timer pins 6:5, clock out 1; serial pins 6:3
   localparam logic [7:0] ALT_ZERO_MASK = 8'h62;
   localparam logic [7:0] ALT_ONE_MASK = 8'h78;
   localparam logic [7:0] EXT_IRQ_MASK = 8'h1C;
   localparam int EXT_IRQ_LSB = 2;
   localparam int EXT_IRQ_N = 3;
   localparam int SHARED_N = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef logic [NUM_PORTS-1:0][PORT_W-1:0] port_arr_t;
   typedef struct packed {
      logic [7:0] int_en;
      logic [7:0] act_low;
      logic [7:0] ttl;
      logic [7:0] open_drain;
      logic [7:0] pull_up;
      logic [7:0] drv_en;
   } port_cfg_t;
   typedef struct packed {
      port_arr_t out;
      port_arr_t oe;
      port_arr_t pull_up;
      port_arr_t ttl;
   } pad_drive_t;
   typedef struct packed {
      logic [7:0] p0_out;
      logic [7:0] p0_oe;
      logic [7:0] p1_out;
      logic [7:0] p1_oe;
   } alt_drive_t;
   typedef struct packed {
      logic ok;
      logic is_data;
      logic is_alt;
      logic [2:0] kind;
      logic [2:0] port;
   } dec_t;
endpackage : gpio_pkg

// *** gpio_ports.sv ***
// gpio ports: axi4-lite registers, pad control and pin interrupts
//
// Overview of operation
// - port zero data register, drives enabled pins
// - data reads return synchronised pin levels
// - port zero timer, irq, clock alternates
// - port one register, serial pins 6 to 3
// - ports two and three full 8 bits
// - port four only low nibble
// - reset: all inputs, pull-ups on
// - enabled interrupt works for input or output
// - disabled pin never interrupts, save the dedicated irq pins
// - interrupts are edge detected
// - shared irq re-arms after all inputs inactive
// - output pin driven active raises interrupt
// - act low bit flips interrupt polarity
// - dedicated irq pins: rising or falling edge
// - ttl threshold select, cmos at reset
// - open drain: one floats, zero drives low
// - driver enable turns output driver on
// - pull-up bit connects pin pull-up
// - dedicated irq pins feed controller directly
`timescale 1ns/100ps
module gpio_ports
   import gpio_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire port_arr_t pad_in,
   output pad_drive_t pads,
   input wire alt_drive_t alt,
   output port_arr_t pin_level,
   output logic [EXT_IRQ_N-1:0] ext_irq,
   output logic [2*PORT_W-1:0] pin_irq,
   output logic [SHARED_N-1:0] shared_irq
);
   ////////////////////////////////////////////////////////////////////////
   // reset release
   logic rst_meta_n;
   logic rst_sync_n;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decode
   function automatic dec_t decode(input logic [IDX_W-1:0] idx);
      logic [7:0] off;
      dec_t d;
      off = idx - IDX_CFG_BASE;
      d = '0;
      d.kind = off[5:3];
      d.port = off[2:0];
      if (idx <= IDX_PORT_FOUR_DATA) begin
         d.ok = 1'b1;
         d.is_data = 1'b1;
         d.port = idx[2:0];
      end else if (idx == IDX_ALT_SEL_ZERO || idx == IDX_ALT_SEL_ONE) begin
         d.ok = 1'b1;
         d.is_alt = 1'b1;
         d.port = idx[2:0];
      end else if (idx >= IDX_CFG_BASE && off[7:6] == 2'h0) begin
         d.ok = (off[5:3] < KIND_LIMIT) && (off[2:0] < PORT_LIMIT);
      end
      return d;
   endfunction : decode

   function automatic logic [7:0] port_mask(input logic [2:0] p);
      return (p == IDX_PORT_FOUR_DATA[2:0]) ? PORT_FOUR_MASK : FULL_MASK;
   endfunction : port_mask

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel
   logic [IDX_W-1:0] aw_idx;
   logic [7:0] w_byte;
   logic w_lane;
   dec_t wr_dec;
   logic wr_fire;
   assign wr_dec = decode(aw_idx);
   // both taken, response not yet out
   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_axi_awready <= 1'b1;
         aw_idx <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_idx <= s_axi_awaddr[IDX_W+1:2];
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_axi_wready <= 1'b1;
         w_byte <= '0;
         w_lane <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_byte <= s_axi_wdata[7:0];
         w_lane <= s_axi_wstrb[0];
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_dec.ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   port_arr_t data_q;
   port_cfg_t cfg [NUM_PORTS];
   logic [7:0] alt_sel [2];
   logic wr_en;
   assign wr_en = wr_fire && wr_dec.ok && w_lane;

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         data_q <= {NUM_PORTS{DATA_RESET}};
      end else if (wr_en && wr_dec.is_data) begin
         // unwritable nibble of port four held at zero
         data_q[wr_dec.port] <= w_byte & port_mask(wr_dec.port);
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            // inputs with pull-ups, cmos threshold
            cfg[p] <= '{int_en: CFG_RESET, act_low: CFG_RESET,
                        ttl: CFG_RESET, open_drain: CFG_RESET,
                        pull_up: PULL_UP_RESET, drv_en: CFG_RESET};
         end
      end else if (wr_en && !wr_dec.is_data && !wr_dec.is_alt) begin
         cfg[wr_dec.port][wr_dec.kind*PORT_W +: PORT_W] <=
            w_byte & port_mask(wr_dec.port);
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         alt_sel[0] <= CFG_RESET;
         alt_sel[1] <= CFG_RESET;
      end else if (wr_en && wr_dec.is_alt) begin
         // only pins with an output alternate can be handed over
         alt_sel[wr_dec.port[0]] <= w_byte &
            (wr_dec.port[0] ? ALT_ONE_MASK : ALT_ZERO_MASK);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers, two flops then a history flop
   port_arr_t s1;
   port_arr_t s2;
   port_arr_t s3;
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         // idle pins sit at pull-up level; zero here faked an edge
         s1 <= '1;
         s2 <= '1;
         s3 <= '1;
      end else begin
         s1 <= pad_in;
         s2 <= s1;
         s3 <= s2;
      end
   end
   // timer, clock-in and serial inputs take these levels
   assign pin_level = s2;

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel
   dec_t rd_dec;
   logic [7:0] rd_byte;
   assign rd_dec = decode(s_axi_araddr[IDX_W+1:2]);
   always_comb begin
      rd_byte = '0;
      if (rd_dec.is_data) begin
         // live pin state, not the written value
         rd_byte = s2[rd_dec.port] & port_mask(rd_dec.port);
      end else if (rd_dec.is_alt) begin
         rd_byte = alt_sel[rd_dec.port[0]];
      end else if (rd_dec.ok) begin
         rd_byte = cfg[rd_dec.port][rd_dec.kind*PORT_W +: PORT_W];
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rd_byte};
         s_axi_rresp <= rd_dec.ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pad drive
   port_arr_t eff_data;
   port_arr_t eff_drv;
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         eff_data[p] = data_q[p];
         eff_drv[p] = cfg[p].drv_en;
      end
      // alternates take over data and driver on selected bits
      eff_data[0] = (alt.p0_out & alt_sel[0]) | (data_q[0] & ~alt_sel[0]);
      eff_drv[0] = (alt.p0_oe & alt_sel[0]) | (cfg[0].drv_en & ~alt_sel[0]);
      eff_data[1] = (alt.p1_out & alt_sel[1]) | (data_q[1] & ~alt_sel[1]);
      eff_drv[1] = (alt.p1_oe & alt_sel[1]) | (cfg[1].drv_en & ~alt_sel[1]);
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pads.out <= '0;
         pads.oe <= '0;
         pads.pull_up <= {NUM_PORTS{PULL_UP_RESET}};
         pads.ttl <= '0;
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            // open drain never drives high
            pads.out[p] <= eff_data[p] & ~cfg[p].open_drain;
            pads.oe[p] <= eff_drv[p] & port_mask(3'(p)) &
               ~(cfg[p].open_drain & eff_data[p]);
            pads.pull_up[p] <= cfg[p].pull_up;
            pads.ttl[p] <= cfg[p].ttl;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin interrupts
   // pin level is used whether the pin is input or output
   port_arr_t act;
   port_arr_t act_prev;
   port_arr_t edge_hit;
   logic [SHARED_N-1:0] any_act;
   logic [SHARED_N-1:0] any_prev;
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         act[p] = s2[p] ^ cfg[p].act_low;
         act_prev[p] = s3[p] ^ cfg[p].act_low;
         edge_hit[p] = act[p] & ~act_prev[p] & cfg[p].int_en;
      end
      for (int i = 0; i < SHARED_N; i++) begin
         any_act[i] = |(act[i+2] & cfg[i+2].int_en);
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         any_prev <= '0;
         shared_irq <= '0;
      end else begin
         any_prev <= any_act;
         // one request per wave of inputs going active
         shared_irq <= any_act & ~any_prev;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pin_irq <= '0;
         ext_irq <= '0;
      end else begin
         pin_irq <= {edge_hit[1], edge_hit[0] & ~EXT_IRQ_MASK};
         // own vectors, gated in the interrupt controller
         ext_irq <= act[0][EXT_IRQ_LSB +: EXT_IRQ_N] &
            ~act_prev[0][EXT_IRQ_LSB +: EXT_IRQ_N];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_sync_n);

   sequence ext_rise_s;
      s2[0][EXT_IRQ_LSB] && !s3[0][EXT_IRQ_LSB] && !cfg[0].act_low[2];
   endsequence
   sequence ext_fall_s;
      !s2[0][EXT_IRQ_LSB] && s3[0][EXT_IRQ_LSB] && cfg[0].act_low[2];
   endsequence

   data_write_a: assert property (
      (wr_en && wr_dec.is_data && wr_dec.port == 3'h0)
      |=> data_q[0] == $past(w_byte))
      else $error("port zero data not stored");
   read_pins_a: assert property (
      (s_axi_arvalid && s_axi_arready && rd_dec.is_data
       && rd_dec.port == 3'h2) |=> s_axi_rdata[7:0] == $past(s2[2]))
      else $error("read did not return pin level");
   port_four_a: assert property (
      data_q[4][7:4] == 4'h0 && pads.oe[4][7:4] == 4'h0)
      else $error("port four reserved bits active");
   no_drive_a: assert property (
      (cfg[3].drv_en == 8'h00) |=> pads.oe[3] == 8'h00)
      else $error("pin driven without driver enable");
   open_drain_a: assert property (
      (cfg[2].open_drain[0] && data_q[2][0]) |=> !pads.oe[2][0])
      else $error("open drain pin driven high");
   drive_level_a: assert property (
      (cfg[3].drv_en[0] && !cfg[3].open_drain[0])
      |=> pads.oe[3][0] && pads.out[3][0] == $past(data_q[3][0]))
      else $error("enabled driver not driving data");
   irq_masked_a: assert property (
      !cfg[1].int_en[0] |=> !pin_irq[PORT_W])
      else $error("interrupt from disabled pin");
   edge_only_a: assert property (
      pin_irq[PORT_W] |=> !pin_irq[PORT_W])
      else $error("pin interrupt held as a level");
   shared_rearm_a: assert property (
      (any_act[0] && any_prev[0]) |=> !shared_irq[0])
      else $error("shared interrupt without re-arm");
   ext_polarity_a: assert property (
      (ext_rise_s or ext_fall_s) |=> ext_irq[0])
      else $error("dedicated interrupt edge missed");
   sync_depth_a: assert property (
      ##2 pin_level == $past(pad_in, 2))
      else $error("pin level not two flops behind pad");
   write_resp_a: assert property (
      wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
      else $error("write response missing");
endmodule : gpio_ports

// *** pin_world.sv ***
// partner: external pin world around the gpio pads
`timescale 1ns/100ps
module pin_world
   import gpio_pkg::*;
(
   input wire logic clock,
   input wire pad_drive_t pads,
   input wire port_arr_t ext_en,
   input wire port_arr_t ext_val,
   output port_arr_t pad_in
);
////////////////////
   // floating pin wanders, so a stale level never passes for a read
   logic flick = 1'h0;
   always @(posedge clock) flick <= ~flick;
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int b = 0; b < PORT_W; b++) begin
            if (pads.oe[p][b]) begin
               pad_in[p][b] = pads.out[p][b];
            end else if (ext_en[p][b]) begin
               pad_in[p][b] = ext_val[p][b];
            end else if (pads.pull_up[p][b]) begin
               pad_in[p][b] = 1'h1;
            end else begin
               pad_in[p][b] = flick;
            end
         end
      end
   end
endmodule : pin_world

// *** gpio_port_data_and_pin_config_tb.sv ***
// testbench: register and pin scenarios for the gpio ports
`timescale 1ns/100ps
module gpio_port_data_and_pin_config_tb
   import gpio_pkg::*;
;
   logic clock;
   logic rst_n;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   port_arr_t pad_in, pin_level, ext_en, ext_val;
   pad_drive_t pads;
   alt_drive_t alt;
   logic [2:0] ext_irq, shared_irq;
   logic [15:0] pin_irq;
   int error_cnt = 0;
   int n_tests = 0;
   int pin_cnt[16];
   int sh_cnt[3];
   int ext_cnt[3];

   initial begin
      clock = 1'h0;
      forever #20 clock = ~clock;
   end

   gpio_ports #(.ADDR_W(12)) dut (.clock, .rst_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .pad_in, .pads, .alt, .pin_level, .ext_irq, .pin_irq, .shared_irq);
   pin_world pw (.clock, .pads, .ext_en, .ext_val, .pad_in);

   // pulses are one cycle wide, so counting them shows edge behaviour
   always @(posedge clock) begin
      for (int i = 0; i < 16; i++) pin_cnt[i] += int'(pin_irq[i] === 1'h1);
      for (int i = 0; i < 3; i++) begin
         sh_cnt[i] += int'(shared_irq[i] === 1'h1);
         ext_cnt[i] += int'(ext_irq[i] === 1'h1);
      end
   end
////////////////////
   task automatic final_report();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string nm, input logic [39:0] seen,
                      input logic [39:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc

   task automatic clr();
      @(negedge clock);
      pin_cnt = '{default: 0};
      sh_cnt = '{default: 0};
      ext_cnt = '{default: 0};
      @(posedge clock);
   endtask : clr

   task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                     input logic [1:0] er = RESP_OKAY);
      @(posedge clock);
      s_axi_awaddr <= {2'h0, idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk("bresp", s_axi_bresp, er);
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [7:0] e,
                     input logic [1:0] er = RESP_OKAY);
      @(posedge clock);
      s_axi_araddr <= {2'h0, idx, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk("rdata", s_axi_rdata, {24'h0, e});
      chk("rresp", s_axi_rresp, er);
   endtask : rd

   task automatic pin(input int p, input logic [7:0] en, input logic [7:0] v);
      @(posedge clock);
      ext_en[p] <= en;
      ext_val[p] <= v;
      cyc(5);
   endtask : pin

   function automatic logic [7:0] cfg(input logic [2:0] k, input int p);
      return IDX_CFG_BASE + {2'h0, k, 3'h0} + 8'(p);
   endfunction : cfg
////////////////////
   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      final_report();
   end

   initial begin
      logic [7:0] m;
      rst_n = 1'h0;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      ext_en = '0;
      ext_val = '0;
      alt = '0;
      repeat (6) @(posedge clock);
      rst_n <= 1'h1;
      cyc(3);
      chk("pull", pads.pull_up, {5{8'hFF}});
      chk("oe", pads.oe, 40'h0);
      chk("ttl", pads.ttl, 40'h0);
      for (int p = 0; p < NUM_PORTS; p++) begin
         m = (p == 4) ? PORT_FOUR_MASK : FULL_MASK;
         rd(8'(p), m);
         wr(8'(p), 8'hA5);
         wr(cfg(KIND_DRV_EN, p), 8'hFF);
         cyc(2);
         chk("drv oe", pads.oe[p], m);
         rd(8'(p), 8'hA5 & m);
         wr(cfg(KIND_DRV_EN, p), 8'h00);
      end
      pin(2, 8'hFF, 8'h3C);
      rd(IDX_PORT_TWO_DATA, 8'h3C);
      chk("level", pin_level[2], 8'h3C);
      wr(cfg(KIND_OPEN_DRAIN, 3), 8'hFF);
      wr(IDX_PORT_THREE_DATA, 8'h0F);
      wr(cfg(KIND_DRV_EN, 3), 8'hFF);
      cyc(2);
      chk("od oe", pads.oe[3], 8'hF0);
      rd(IDX_PORT_THREE_DATA, 8'h0F);
      wr(cfg(KIND_OPEN_DRAIN, 3), 8'h00);
      cyc(2);
      chk("pp oe", pads.oe[3], 8'hFF);
      rd(IDX_PORT_THREE_DATA, 8'h0F);
      wr(cfg(KIND_PULL_UP, 1), 8'h00);
      wr(cfg(KIND_TTL, 2), 8'h81);
      cyc(2);
      chk("pull", pads.pull_up[1], 8'h00);
      chk("ttl", pads.ttl[2], 8'h81);
      rd(cfg(KIND_TTL, 2), 8'h81);
      s_axi_wstrb <= 4'h0;
      wr(cfg(KIND_TTL, 2), 8'h00);
      s_axi_wstrb <= 4'hF;
      cyc(2);
      chk("ttl kept", pads.ttl[2], 8'h81);
      rd(cfg(KIND_TTL, 2), 8'h81);
      // port one: bits 0 and 2 driven outside, bit 7 driven by us
      pin(1, 8'h05, 8'h00);
      wr(cfg(KIND_ACT_LOW, 1), 8'h04);
      wr(cfg(KIND_INT_EN, 1), 8'h85);
      wr(IDX_PORT_ONE_DATA, 8'h00);
      wr(cfg(KIND_DRV_EN, 1), 8'h80);
      cyc(4);
      clr();
      pin(1, 8'h05, 8'h01);
      cyc(4);
      chk("rise", pin_cnt[8], 1);
      pin(1, 8'h05, 8'h05);
      chk("low rise", pin_cnt[10], 0);
      pin(1, 8'h05, 8'h01);
      chk("low fall", pin_cnt[10], 1);
      wr(IDX_PORT_ONE_DATA, 8'h80);
      cyc(5);
      chk("out", pin_cnt[15], 1);
      for (int b = 9; b < 15; b++) begin
         if (b != 10) chk("off", pin_cnt[b], 0);
      end
      wr(cfg(KIND_INT_EN, 2), 8'h03);
      pin(2, 8'hFF, 8'h00);
      clr();
      pin(2, 8'hFF, 8'h01);
      pin(2, 8'hFF, 8'h03);
      pin(2, 8'hFF, 8'h02);
      chk("shared", sh_cnt[0], 1);
      pin(2, 8'hFF, 8'h00);
      pin(2, 8'hFF, 8'h02);
      chk("rearm", sh_cnt[0], 2);
      // flipping polarity can fire by itself, so counts clear after
      pin(0, 8'h1C, 8'h08);
      wr(cfg(KIND_ACT_LOW, 0), 8'h08);
      cyc(4);
      clr();
      pin(0, 8'h1C, 8'h0C);
      chk("ext a", ext_cnt[0], 1);
      pin(0, 8'h1C, 8'h04);
      chk("ext b", ext_cnt[1], 1);
      pin(0, 8'h1C, 8'h14);
      chk("ext c", ext_cnt[2], 1);
      alt <= '{p0_out: 8'h42, p0_oe: 8'h62, p1_out: 8'h50, p1_oe: 8'h78};
      wr(IDX_ALT_SEL_ZERO, 8'hFF);
      wr(IDX_ALT_SEL_ONE, 8'hFF);
      cyc(2);
      chk("alt0 oe", pads.oe[0] & ALT_ZERO_MASK, ALT_ZERO_MASK);
      chk("alt0 out", pads.out[0] & ALT_ZERO_MASK, 8'h42);
      chk("alt1 oe", pads.oe[1] & ALT_ONE_MASK, ALT_ONE_MASK);
      chk("alt1 out", pads.out[1] & ALT_ONE_MASK, 8'h50);
      rd(IDX_ALT_SEL_ONE, ALT_ONE_MASK);
      wr(8'h15, 8'h11, RESP_SLVERR);
      rd(8'h15, 8'h00, RESP_SLVERR);
      final_report();
   end
endmodule : gpio_port_data_and_pin_config_tb
